/* include/pcg_pkg.sv */
// Constants and types shared by the peripheral clock gate bank.
package pcg_pkg;

	localparam int PCG_ADDR_W = 16;
	localparam int PCG_NREG = 4;
	localparam int PCG_NCLK = 15;

	// Register indices; the byte address is four times the index.
	localparam logic [15:0] PCG_IDX_TIMER = 16'h0f74;
	localparam logic [15:0] PCG_IDX_SERIAL = 16'h0f75;
	localparam logic [15:0] PCG_IDX_MISC = 16'h0f76;
	localparam logic [15:0] PCG_IDX_IRQ = 16'h0f77;

	localparam logic [7:0] PCG_GATE_RST = 8'h00;
	localparam logic [31:0] PCG_RDATA_RST = 32'h0000_0000;

	// Field positions inside the gate registers.
	localparam int PCG_B_TMR_B = 5;
	localparam int PCG_B_TMR_A = 4;
	localparam int PCG_B_WIDE1 = 1;
	localparam int PCG_B_WIDE0 = 0;
	localparam int PCG_B_I2C = 4;
	localparam int PCG_B_UART1 = 1;
	localparam int PCG_B_UART0 = 0;
	localparam int PCG_B_RTC = 5;
	localparam int PCG_B_SIO = 0;

	typedef struct packed {
		logic [7:0] irq;
		logic [7:0] misc;
		logic [7:0] serial;
		logic [7:0] timer;
	} pcg_gates_t;

	typedef struct packed {
		logic [5:0] ext_irq;
		logic realtime_clock;
		logic sync_serial;
		logic i2c_unit;
		logic uart_one;
		logic uart_zero;
		logic timer_pair_b;
		logic timer_pair_a;
		logic wide_timer_one;
		logic wide_timer_zero;
	} pcg_clks_t;

endpackage

/* verilog/pcg_gate_cell.sv */
// Glitch-free latch-based clock gate for one peripheral clock.
`timescale 1ns/10ps
module pcg_gate_cell (
	input wire logic clk,
	input wire logic en,
	output logic gclk
);
	logic en_l;

	// The latch is open only while clk is low, so the enable cannot
	// change during the high phase and no runt pulse can form.
	always_latch begin
		if (!clk) begin
			en_l <= en;
		end
	end

	assign gclk = clk & en_l;

endmodule // pcg_gate_cell

/* verilog/pcg_clock_gate_bank.sv */
// Peripheral clock gate bank with an Avalon-MM register slave.
`timescale 1ns/10ps
module pcg_clock_gate_bank
	import pcg_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [PCG_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output pcg_gates_t gate_state,
	output pcg_clks_t peri_clk
);

	////////////////////////////////////////////////////////////////////////
	// Bus slave state.

	pcg_gates_t gate_r, gate_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic req, acc, hit;
	logic [1:0] sel;
	logic [7:0] cur;

	assign req = avs_read | avs_write;
	// The answer comes on the edge after the one where the request is
	// first seen; one wait cycle keeps the decode off the critical path.
	assign acc = req & ~wait_r;

	always_comb begin
		hit = (avs_address[1:0] == 2'b00);
		sel = 2'b00;
		unique case (avs_address[PCG_ADDR_W-1:2])
			PCG_IDX_TIMER[PCG_ADDR_W-3:0]: sel = 2'd0;
			PCG_IDX_SERIAL[PCG_ADDR_W-3:0]: sel = 2'd1;
			PCG_IDX_MISC[PCG_ADDR_W-3:0]: sel = 2'd2;
			PCG_IDX_IRQ[PCG_ADDR_W-3:0]: sel = 2'd3;
			default: hit = 1'b0;
		endcase
		cur = gate_r[sel*8 +: 8];
	end

	always_comb begin
		gate_nxt = gate_r;
		rdata_nxt = rdata_r;
		wait_nxt = 1'b1;
		if (req && wait_r) begin
			wait_nxt = 1'b0;
			// Unmapped addresses read as zero and ignore writes.
			rdata_nxt = hit ? {24'h00_0000, cur} : 32'h0000_0000;
		end
		if (acc && avs_write && hit && avs_byteenable[0]) begin
			gate_nxt[sel*8 +: 8] = avs_writedata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			gate_r <= '{irq: PCG_GATE_RST, misc: PCG_GATE_RST,
				serial: PCG_GATE_RST, timer: PCG_GATE_RST};
			wait_r <= 1'b1;
			rdata_r <= PCG_RDATA_RST;
		end else begin
			gate_r <= gate_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign gate_state = gate_r;

	////////////////////////////////////////////////////////////////////////
	// Clock gates.

	logic [PCG_NCLK-1:0] en;
	logic [PCG_NCLK-1:0] gclk;

	always_comb begin
		en[0] = gate_r.timer[PCG_B_WIDE0];
		en[1] = gate_r.timer[PCG_B_WIDE1];
		en[2] = gate_r.timer[PCG_B_TMR_A];
		en[3] = gate_r.timer[PCG_B_TMR_B];
		en[4] = gate_r.serial[PCG_B_UART0];
		en[5] = gate_r.serial[PCG_B_UART1];
		en[6] = gate_r.serial[PCG_B_I2C];
		en[7] = gate_r.misc[PCG_B_SIO];
		en[8] = gate_r.misc[PCG_B_RTC];
		en[14:9] = gate_r.irq[5:0];
	end

	// Gated clocks cannot come from a flip-flop; each leaves its gate
	// cell directly, and the registered enable reaches it by the next
	// low phase of clk.
	genvar gi;
	generate
		for (gi = 0; gi < PCG_NCLK; gi++) begin : g_gate
			pcg_gate_cell u_cell (
				.clk(clk),
				.en(en[gi]),
				.gclk(gclk[gi])
			);
		end
	endgenerate

	assign peri_clk = pcg_clks_t'(gclk);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [PCG_NCLK-1:0] en_prev_r;
	always_ff @(posedge clk) begin
		en_prev_r <= en;
	end

	sequence s_write_acc(logic [15:0] idx);
		acc && avs_write && avs_byteenable[0] &&
			avs_address == {idx[PCG_ADDR_W-3:0], 2'b00};
	endsequence

	chk_gate_stops: assert property (@(negedge clk) disable iff (!rstn)
		(gclk & ~en_prev_r) == '0)
		else $error("Gated clock runs while its gate bit is zero.");

	chk_gate_runs: assert property (@(negedge clk) disable iff (!rstn)
		(~gclk & en_prev_r) == '0)
		else $error("Gated clock stopped while its gate bit is one.");

	chk_reset_clear: assert property (@(posedge clk) disable iff (!rstn)
		$past(!rstn) |-> (gate_r == '0 && peri_clk == '0))
		else $error("Gate registers not clear after reset.");

	chk_timer_map: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_TIMER) |=> en[3:0] == {$past(avs_writedata[5]),
			$past(avs_writedata[4]), $past(avs_writedata[1]),
			$past(avs_writedata[0])})
		else $error("Timer gate bits mapped wrongly.");

	chk_serial_map: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_SERIAL) |=> en[6:4] == {$past(avs_writedata[4]),
			$past(avs_writedata[1]), $past(avs_writedata[0])})
		else $error("Serial gate bits mapped wrongly.");

	chk_misc_map: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_MISC) |=> en[8:7] == {$past(avs_writedata[5]),
			$past(avs_writedata[0])})
		else $error("Misc gate bits mapped wrongly.");

	chk_reg_readback: assert property (@(posedge clk) disable iff (!rstn)
		(req && wait_r && avs_read && hit) |=> ##0 !wait_r ##0
			avs_readdata == {24'h00_0000, $past(cur)})
		else $error("Register readback differs from stored value.");

	chk_irq_map: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_IRQ) |=> gate_r.irq == $past(avs_writedata[7:0])
			&& en[14:9] == $past(avs_writedata[5:0]))
		else $error("Interrupt gate register not written as expected.");

	chk_no_runt: assert property (@(posedge clk) disable iff (!rstn)
		gclk == '0)
		else $error("Gated clock high during the low phase of clk.");

	chk_write_timing: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_IRQ) |-> ##2 en_prev_r[14:9] ==
			$past(avs_writedata[5:0], 2))
		else $error("Written gate value late at the gated clock.");

	////////////////////////////////////////////////////////////////////////
	// Bus handshake checks.

	// A master that counts on a fixed latency breaks if the single wait
	// cycle ever grows, so the answer shape is pinned down here.
	sequence s_req_fresh;
		req && wait_r;
	endsequence

	sequence s_answer_once;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	chk_one_wait: assert property (@(posedge clk) disable iff (!rstn)
		s_req_fresh |=> s_answer_once)
		else $error("Bus answer not given after exactly one wait cycle.");

	chk_idle_wait: assert property (@(posedge clk) disable iff (!rstn)
		!req |=> avs_waitrequest)
		else $error("Waitrequest low without a request.");

	chk_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
		!(req && wait_r) |=> $stable(avs_readdata))
		else $error("Read data changed without a new request.");

	chk_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
		(req && wait_r && avs_read && !hit) |=> avs_readdata == '0)
		else $error("Unmapped read did not return zero.");

	chk_drop_write: assert property (@(posedge clk) disable iff (!rstn)
		(acc && avs_write && !(hit && avs_byteenable[0])) |=>
			$stable(gate_r))
		else $error("Dropped write changed a gate register.");

	chk_hold_gates: assert property (@(posedge clk) disable iff (!rstn)
		!(acc && avs_write) |=> $stable(gate_r))
		else $error("Gate register changed without a write.");

	chk_reset_idle: assert property (@(posedge clk) disable iff (!rstn)
		$past(!rstn) |-> (avs_waitrequest && avs_readdata == '0 &&
			gate_state == '0))
		else $error("Bus outputs not idle after reset.");

	// Spare bits have no clock behind them, so only a full-byte compare
	// shows that they are stored as well.
	chk_timer_store: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_TIMER) |=> gate_r.timer ==
			$past(avs_writedata[7:0]))
		else $error("Timer gate register not stored as written.");

	chk_serial_store: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_SERIAL) |=> gate_r.serial ==
			$past(avs_writedata[7:0]))
		else $error("Serial gate register not stored as written.");

	chk_misc_store: assert property (@(posedge clk) disable iff (!rstn)
		s_write_acc(PCG_IDX_MISC) |=> gate_r.misc ==
			$past(avs_writedata[7:0]))
		else $error("Misc gate register not stored as written.");

endmodule // pcg_clock_gate_bank

/* sim/pcg_peri_model.sv */
// Model of the peripheral clock inputs that counts gated clock edges.
`timescale 1ns/10ps
module pcg_peri_model
	import pcg_pkg::*;
(
	input wire logic rstn,
	input wire pcg_clks_t peri_clk,
	output logic [7:0] cnt [PCG_NCLK]
);
	// Sinks keep only edge counts, so a gate cleared mid-use is harmless.
	// Sinks have no setup of their own, so no gate needs to be set first.
	for (genvar i = 0; i < PCG_NCLK; i++) begin : g_sink
		always @(posedge peri_clk[i] or negedge rstn) begin
			if (!rstn) begin
				cnt[i] <= 8'h00;
			end else begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
	end
endmodule // pcg_peri_model

/* sim/testbench.sv */
// Self-checking testbench for the peripheral clock gate bank.
`timescale 1ns/10ps
module testbench
	import pcg_pkg::*;
;
	logic clk = 1'b0;
	logic rstn;
	logic [15:0] a_r = 16'h0000;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [31:0] wd_r = 32'h0000_0000;
	logic [3:0] be_r = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pcg_gates_t gate_state;
	pcg_clks_t peri_clk;
	logic [7:0] cnt [PCG_NCLK];
	logic [7:0] m [4];
	logic [31:0] rd;
	int n_mismatch = 0;
	int checked = 0;
	pcg_clock_gate_bank DUT (.clk(clk), .rstn(rstn), .avs_address(a_r),
		.avs_read(rd_r), .avs_write(wr_r), .avs_writedata(wd_r),
		.avs_byteenable(be_r), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .gate_state(gate_state),
		.peri_clk(peri_clk));
	pcg_peri_model peri (.rstn(rstn), .peri_clk(peri_clk), .cnt(cnt));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// The request stays put until waitrequest is seen low at an edge.
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic [3:0] be);
		@(posedge clk);
		a_r <= a;
		wr_r <= w;
		rd_r <= !w;
		wd_r <= {24'($urandom), d};
		be_r <= be;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
	endtask
	function automatic logic [31:0] want_clk();
		return {17'h0, m[3][5:0], m[2][5], m[2][0], m[1][4], m[1][1],
			m[1][0], m[0][5], m[0][4], m[0][1], m[0][0]};
	endfunction
	task automatic verify();
		logic [7:0] base [PCG_NCLK];
		logic [31:0] seen;
		#1;
		check(gate_state, {m[3], m[2], m[1], m[0]});
		base = cnt;
		repeat (4) @(posedge clk);
		#1;
		seen = 32'h0;
		for (int i = 0; i < PCG_NCLK; i++) begin
			seen[i] = (cnt[i] !== base[i]);
		end
		check(seen, want_clk());
		for (int r = 0; r < 4; r++) begin
			bus(1'b0, 16'h3dd0 + 16'(4 * r), 8'h00, 4'hf);
			check(rd, {24'h0, m[r]});
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2.5 clk = ~clk;
	end
	// The span allows about fifty times the expected run length.
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [1:0] r;
		logic [7:0] d;
		rstn <= 1'b0;
		void'($urandom(32'h82ea));
		m = '{default: 8'h00};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		verify();
		for (int k = 0; k < 30; k++) begin
			r = (k < 8) ? 2'(k) : 2'($urandom);
			d = (k < 4) ? 8'hff : ((k < 8) ? 8'h00 : 8'($urandom));
			bus(1'b1, 16'h3dd0 + {12'h0, r, 2'b00}, d, {3'($urandom), 1'b1});
			m[r] = d;
			if (k % 3 == 0 || k < 8) begin
				verify();
			end
		end
		// Unmapped, misaligned and lane-disabled writes are all dropped.
		bus(1'b1, 16'h3de0, 8'h5a, 4'hf);
		bus(1'b0, 16'h3de0, 8'h00, 4'hf);
		check(rd, 32'h0);
		bus(1'b1, 16'h3dd1, 8'h5a, 4'hf);
		bus(1'b1, 16'h3dd4, 8'h5a, 4'he);
		verify();
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		m = '{default: 8'h00};
		verify();
		conclude();
	end
endmodule // testbench
